// ---- common/supply_monitor_pkg.sv ----
// constants, field layout and carrier types for the supply monitor control block
package supply_monitor_pkg;

	// bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [3:0] OFF_MONITOR_CONTROL = 4'h0;
	localparam logic [3:0] OFF_THRESHOLD = 4'h1;
	localparam logic [3:0] OFF_WARN_CONTROL = 4'h8;
	localparam logic [3:0] OFF_IRQ_CONTROL = 4'h9;
	localparam logic [3:0] OFF_IRQ_FLAGS = 4'hA;
	localparam logic [3:0] OFF_STATUS = 4'hB;
	localparam logic [3:0] OFF_PROTECT_KEY = 4'hF;

	// field positions
	localparam int POS_SLEEP = 0;
	localparam int POS_ACTIVE = 2;
	localparam int POS_SAMP_FREQ = 4;
	localparam int POS_IRQ_ENABLE = 0;
	localparam int POS_TRIGGER = 1;
	localparam int POS_FLAG = 0;
	localparam int POS_BELOW = 0;

	// reset values of software-owned fields
	localparam logic [1:0] RST_WARN_LEVEL = 2'h0;
	localparam logic [1:0] RST_TRIGGER = 2'h0;
	localparam logic RST_IRQ_ENABLE = 1'b0;

	// protection key and the number of cycles it keeps the sleep field open
	localparam logic [7:0] PROTECT_KEY_VALUE = 8'hD8;
	localparam logic [2:0] PROTECT_WINDOW_CYCLES = 3'h4;

	// monitor modes
	localparam logic [1:0] MODE_DISABLED = 2'h0;
	localparam logic [1:0] MODE_ENABLED = 2'h1;
	localparam logic [1:0] MODE_SAMPLED = 2'h2;
	localparam logic [1:0] MODE_ENABLED_HOLD = 2'h3;

	// trigger selections
	localparam logic [1:0] TRIG_FROM_ABOVE = 2'h0;
	localparam logic [1:0] TRIG_FROM_BELOW = 2'h1;
	localparam logic [1:0] TRIG_EITHER = 2'h2;

	// timing: clock period and the two sample periods
	localparam int CLK_PERIOD_NS = 100;
	localparam int SAMPLE_FAST_PERIOD_US = 1000;
	localparam int SAMPLE_SLOW_PERIOD_US = 8000;
	localparam int SAMPLE_FAST_CYCLES = SAMPLE_FAST_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int SAMPLE_SLOW_CYCLES = SAMPLE_SLOW_PERIOD_US * 1000 / CLK_PERIOD_NS;

	// non-volatile configuration word presented at reset
	typedef struct packed {
		logic samp_freq;
		logic [1:0] active;
		logic [1:0] sleep;
		logic [2:0] level;
	} fuse_cfg_s;

	// one register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

endpackage : supply_monitor_pkg

// ---- dv/supply_comparator_model.sv ----
// behavioural model of the analog comparators facing the monitor control block
`timescale 1ns/10ps
`default_nettype none

module supply_comparator_model (
	input wire logic clk_sys,
	input wire logic brownout_cmp_en,
	input wire logic warn_cmp_en,
	input wire logic [2:0] brownout_level,
	input wire logic [1:0] warn_level_select,
	input wire logic [7:0] supply,
	output logic below_brownout,
	output logic below_warn,
	output logic monitor_ready
);
	int bo_thr;
	int warn_thr;
	int pct;
	int on_cnt = 0;
	logic junk = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// thresholds in arbitrary supply units; warning sits a percentage above brownout
	always_comb begin
		bo_thr = 60 + 10 * int'(brownout_level);
		case (warn_level_select)
			2'h0: pct = 5;
			2'h1: pct = 15;
			default: pct = 25;
		endcase
		warn_thr = bo_thr * (100 + pct) / 100;
	end

	////////////////////////////////////////////////////////////////////////////////
	// a powered-down comparator gives no trustworthy answer, so it toggles
	always @(posedge clk_sys) begin
		junk <= ~junk;
		on_cnt <= brownout_cmp_en ? on_cnt + 1 : 0;
	end

	// outputs only mean something while the comparator is enabled
	assign below_brownout = brownout_cmp_en ? (int'(supply) < bo_thr) : junk;
	assign below_warn = warn_cmp_en ? (int'(supply) < warn_thr) : junk;
	assign monitor_ready = brownout_cmp_en && (on_cnt >= 3);

endmodule : supply_comparator_model
`default_nettype wire

// ---- dv/test_supply_monitor_control.sv ----
// self-checking testbench for the supply monitor control block
`timescale 1ns/10ps
`default_nettype none

module test_supply_monitor_control;
	localparam int FAST = 8;
	localparam int SLOW = 16;
	// bit positions of the single-bit outputs inside the peek word
	localparam int O_CMP = 0;
	localparam int O_WARN = 1;
	localparam int O_RST = 2;
	localparam int O_IRQ = 3;
	localparam int O_HOLD = 4;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	supply_monitor_pkg::reg_req_s req = '0;
	supply_monitor_pkg::fuse_cfg_s fuse_cfg = '0;
	logic deep_sleep = 1'b0;
	logic debug_halt = 1'b0;
	logic [7:0] supply = 8'hC8;
	logic [7:0] rd_data;
	logic below_brownout;
	logic below_warn;
	logic monitor_ready;
	logic brownout_cmp_en;
	logic warn_cmp_en;
	logic system_reset_req;
	logic irq_req;
	logic wake_hold;
	logic [2:0] brownout_level;
	logic [1:0] warn_level_select;
	logic [2:0] lvl;
	logic [7:0] outs;
	// read late by peek, so the value seen is the one the last edge launched
	assign outs = {3'h0, wake_hold, irq_req, system_reset_req, warn_cmp_en, brownout_cmp_en};
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;
	int bo_thr;
	int pulses;
	int wpulses;

	supply_monitor_control #(.SAMPLE_FAST_CYCLES(FAST), .SAMPLE_SLOW_CYCLES(SLOW))
		i_supply_monitor_control (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
		.req(req), .rd_data(rd_data), .fuse_cfg(fuse_cfg), .deep_sleep(deep_sleep),
		.debug_halt(debug_halt), .below_brownout(below_brownout), .below_warn(below_warn),
		.monitor_ready(monitor_ready), .brownout_cmp_en(brownout_cmp_en),
		.warn_cmp_en(warn_cmp_en), .brownout_level(brownout_level),
		.warn_level_select(warn_level_select), .system_reset_req(system_reset_req),
		.irq_req(irq_req), .wake_hold(wake_hold));

	supply_comparator_model i_supply_comparator_model (.clk_sys(clk_sys),
		.brownout_cmp_en(brownout_cmp_en), .warn_cmp_en(warn_cmp_en),
		.brownout_level(brownout_level), .warn_level_select(warn_level_select),
		.supply(supply), .below_brownout(below_brownout), .below_warn(below_warn),
		.monitor_ready(monitor_ready));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; under two hundred cycles are expected, so 5000 means a hang
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers: wr, rd and peek start and end on a rising edge
	task automatic summarize();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// look at a settled output one step after the edge
	// the index picks a bit of outs; a value argument would be copied at the edge itself
	task automatic peek(input int b, input logic exp);
		#1;
		check(8'(outs[b]), 8'(exp));
		@(posedge clk_sys);
	endtask : peek

	// one-cycle write strobe, then an idle cycle so strobes never collide
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_sys);
		req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		check(rd_data, exp);
		@(posedge clk_sys);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: fuse active mode enabled, sleep mode disabled, random level
	initial begin
		void'($urandom(5));
		lvl = 3'($urandom % 8);
		bo_thr = 60 + 10 * int'(lvl);
		fuse_cfg <= {1'b0, 2'h1, 2'h0, lvl};
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h04);
		rd(supply_monitor_pkg::OFF_THRESHOLD, {5'h00, lvl});
		check({5'h00, brownout_level}, {5'h00, lvl});
		wr(supply_monitor_pkg::OFF_THRESHOLD, {5'h00, ~lvl});
		rd(supply_monitor_pkg::OFF_THRESHOLD, {5'h00, lvl});
		rd(4'h5, 8'h00);
		rd(supply_monitor_pkg::OFF_PROTECT_KEY, 8'h00);
		// unprotected write to the sleep field must be dropped
		wr(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h02);
		rd(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h04);
		wr(supply_monitor_pkg::OFF_PROTECT_KEY, supply_monitor_pkg::PROTECT_KEY_VALUE);
		wr(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h1A);
		rd(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h06);
		wr(supply_monitor_pkg::OFF_WARN_CONTROL, 8'h02);
		rd(supply_monitor_pkg::OFF_WARN_CONTROL, 8'h02);
		check({6'h00, warn_level_select}, 8'h02);
		// a frozen block ignores a write and keeps its state
		clk_en <= 1'b0;
		wr(supply_monitor_pkg::OFF_WARN_CONTROL, 8'h01);
		clk_en <= 1'b1;
		rd(supply_monitor_pkg::OFF_WARN_CONTROL, 8'h02);
		peek(O_CMP, 1'b1);
		// each defined trigger code: a drop below the warning level, then a recovery
		for (int t = 0; t < 3; t++) begin
			wr(supply_monitor_pkg::OFF_IRQ_CONTROL, 8'h00);
			wr(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h01);
			wr(supply_monitor_pkg::OFF_IRQ_CONTROL, 8'(t * 2 + 1));
			peek(O_WARN, 1'b1);
			rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'(t == 2));
			wr(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h01);
			rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h00);
			supply <= 8'(bo_thr + 2);
			repeat (4) @(posedge clk_sys);
			rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'(t != 1));
			peek(O_IRQ, t != 1);
			wr(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h01);
			supply <= 8'hC8;
			repeat (4) @(posedge clk_sys);
			rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'(t != 0));
		end
		wr(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h00);
		rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h01);
		// a halted core sees no request, but the flag survives
		debug_halt <= 1'b1;
		@(posedge clk_sys);
		peek(O_IRQ, 1'b0);
		rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h01);
		debug_halt <= 1'b0;
		@(posedge clk_sys);
		peek(O_IRQ, 1'b1);
		supply <= 8'(bo_thr - 5);
		repeat (3) @(posedge clk_sys);
		peek(O_RST, 1'b1);
		supply <= 8'hC8;
		repeat (3) @(posedge clk_sys);
		peek(O_RST, 1'b0);
		// deep sleep with the sleep field at sampled: two strobes in 20 cycles, and a drop
		// below the warning level that sampled mode must not flag under the either select
		wr(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h01);
		deep_sleep <= 1'b1;
		supply <= 8'(bo_thr + 2);
		pulses = 0;
		wpulses = 0;
		repeat (20) begin
			@(posedge clk_sys);
			#1;
			pulses += int'(brownout_cmp_en);
			wpulses += int'(warn_cmp_en);
		end
		@(posedge clk_sys);
		check(8'(pulses), 8'h02);
		check(8'(wpulses), 8'h02);
		rd(supply_monitor_pkg::OFF_IRQ_FLAGS, 8'h00);
		rd(supply_monitor_pkg::OFF_STATUS, 8'h01);
		deep_sleep <= 1'b0;
		supply <= 8'hC8;
		@(posedge clk_sys);
		peek(O_CMP, 1'b1);
		// sleep field disabled: both comparators off although the enable is set
		wr(supply_monitor_pkg::OFF_PROTECT_KEY, supply_monitor_pkg::PROTECT_KEY_VALUE);
		wr(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h00);
		deep_sleep <= 1'b1;
		repeat (2) @(posedge clk_sys);
		peek(O_CMP, 1'b0);
		peek(O_WARN, 1'b0);
		deep_sleep <= 1'b0;
		@(posedge clk_sys);
		peek(O_WARN, 1'b1);
		// second reset: the active field now holds wake-up until the comparator is ready
		sys_rst <= 1'b1;
		fuse_cfg <= {1'b0, 2'h3, 2'h0, lvl};
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(supply_monitor_pkg::OFF_MONITOR_CONTROL, 8'h0C);
		rd(supply_monitor_pkg::OFF_IRQ_CONTROL, 8'h00);
		deep_sleep <= 1'b1;
		repeat (2) @(posedge clk_sys);
		deep_sleep <= 1'b0;
		@(posedge clk_sys);
		peek(O_HOLD, 1'b1);
		repeat (2) @(posedge clk_sys);
		peek(O_HOLD, 1'b0);
		summarize();
	end

endmodule : test_supply_monitor_control
`default_nettype wire

// ---- rtl/monitor_sampler.sv ----
// periodic sample strobe generator for sampled monitor mode
`timescale 1ns/10ps
`default_nettype none

module monitor_sampler #(
	parameter int CNT_W = 17,
	parameter int FAST_CYCLES = supply_monitor_pkg::SAMPLE_FAST_CYCLES,
	parameter int SLOW_CYCLES = supply_monitor_pkg::SAMPLE_SLOW_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic run,
	input wire logic slow,
	output logic tick
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] reload;
	logic tick_q;

	assign reload = slow ? CNT_W'(SLOW_CYCLES - 1) : CNT_W'(FAST_CYCLES - 1);
	assign tick = tick_q;

	// count down while running; restart from a full period whenever stopped
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			tick_q <= run && (cnt_q == '0);
			if (!run || cnt_q == '0) begin
				cnt_q <= reload;
			end else begin
				cnt_q <= cnt_q - CNT_W'(1);
			end
		end
	end

endmodule : monitor_sampler
`default_nettype wire

// ---- rtl/supply_monitor_control.sv ----
// supply brownout monitor control with early-warning level monitor
`timescale 1ns/10ps
`default_nettype none
//
// What this block does
// R1: reset loads sleep, active, sample frequency and level from configuration fuses
// R2: threshold and active mode fixed, writes ignored
// R3: sleep mode from fuse, software may overwrite
// R4: enabled runs always, sampled runs once per period
// R5: supply below threshold requests system reset
// R6: warning threshold is percentage above brownout
// R7: enable bit one switches early warning on
// R8: trigger select picks fall, rise or both
// R9: warning follows brownout mode, off when off
// R10: enabling with either-direction select sets flag unless the monitor mode is disabled
// R11: warning level comes from warn control register
// R12: sampled mode: only trigger code one fires
// R13: crossing sets flag; request while flag and enable
// R14: deep sleep entry switches to sleep mode
// R15: wake-up returns to active mode
// R16: monitor runs on clk_sys with clk_en, not on a low-power clock of its own
// R17: debug leaves monitoring; request withheld while halted
// R18: trigger codes: above, below, either, rest reserved
// R19: mode codes: off, on, sampled, on with hold
// R20: level codes give five, fifteen, twenty-five percent
// R21: sleep field writable only after protection key
// R22: writing one clears flag, zero leaves it

module supply_monitor_control #(
	parameter int SAMPLE_FAST_CYCLES = supply_monitor_pkg::SAMPLE_FAST_CYCLES,
	parameter int SAMPLE_SLOW_CYCLES = supply_monitor_pkg::SAMPLE_SLOW_CYCLES
) (
	input wire logic clk_sys, // R16
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire supply_monitor_pkg::reg_req_s req,
	output logic [supply_monitor_pkg::DATA_W-1:0] rd_data,
	input wire supply_monitor_pkg::fuse_cfg_s fuse_cfg,
	input wire logic deep_sleep,
	input wire logic debug_halt,
	input wire logic below_brownout,
	input wire logic below_warn,
	input wire logic monitor_ready,
	output logic brownout_cmp_en,
	output logic warn_cmp_en,
	output logic [2:0] brownout_level,
	output logic [1:0] warn_level_select,
	output logic system_reset_req,
	output logic irq_req,
	output logic wake_hold
);

	////////////////////////////////////////////////////////////////////////////
	// configuration and control registers

	logic samp_freq_q;
	logic [1:0] active_q;
	logic [1:0] sleep_q;
	logic [2:0] level_q;
	logic [1:0] warn_level_q;
	logic [1:0] trigger_q;
	logic irq_enable_q;
	logic flag_q;
	logic below_q;
	logic prev_valid_q;
	logic system_reset_q;
	logic [2:0] key_cnt_q;
	logic [7:0] rd_data_q;

	logic wr_mon;
	logic wr_key;
	logic wr_irq_ctrl;
	logic clear_flag;
	logic [1:0] mode_eff;
	logic sample_tick;
	logic warn_sample;
	logic drop;
	logic recover;
	logic crossing;
	logic enable_edge;
	logic set_flag;

	assign wr_mon = req.wr && req.addr == supply_monitor_pkg::OFF_MONITOR_CONTROL;
	assign wr_key = req.wr && req.addr == supply_monitor_pkg::OFF_PROTECT_KEY;
	assign wr_irq_ctrl = req.wr && req.addr == supply_monitor_pkg::OFF_IRQ_CONTROL;
	assign clear_flag = req.wr && req.addr == supply_monitor_pkg::OFF_IRQ_FLAGS
		&& req.wdata[supply_monitor_pkg::POS_FLAG];

	// fuse-owned fields: loaded on every reset, never written by software
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			samp_freq_q <= fuse_cfg.samp_freq; // R1
			active_q <= fuse_cfg.active; // R1
			level_q <= fuse_cfg.level; // R1 R2
		end
	end

	// key window: a key write opens a short window, a monitor control write closes it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			key_cnt_q <= 3'h0;
		end else if (clk_en) begin
			if (wr_key && req.wdata == supply_monitor_pkg::PROTECT_KEY_VALUE) begin
				key_cnt_q <= supply_monitor_pkg::PROTECT_WINDOW_CYCLES; // R21
			end else if (wr_mon || key_cnt_q == 3'h0) begin
				key_cnt_q <= 3'h0;
			end else begin
				key_cnt_q <= key_cnt_q - 3'h1;
			end
		end
	end

	// sleep mode starts from the fuse, then only a protected write changes it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sleep_q <= fuse_cfg.sleep; // R1 R3
		end else if (clk_en && wr_mon && key_cnt_q != 3'h0) begin
			sleep_q <= req.wdata[supply_monitor_pkg::POS_SLEEP +: 2]; // R3 R21
		end
	end

	// warning level and interrupt control, plain software fields
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			warn_level_q <= supply_monitor_pkg::RST_WARN_LEVEL;
			trigger_q <= supply_monitor_pkg::RST_TRIGGER;
			irq_enable_q <= supply_monitor_pkg::RST_IRQ_ENABLE;
		end else if (clk_en) begin
			if (req.wr && req.addr == supply_monitor_pkg::OFF_WARN_CONTROL) begin
				warn_level_q <= req.wdata[1:0]; // R11 R20
			end
			if (wr_irq_ctrl) begin
				trigger_q <= req.wdata[supply_monitor_pkg::POS_TRIGGER +: 2]; // R8 R18
				irq_enable_q <= req.wdata[supply_monitor_pkg::POS_IRQ_ENABLE]; // R7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode selection and comparator enables

	// deep sleep uses the sleep field, otherwise the active field
	assign mode_eff = deep_sleep ? sleep_q : active_q; // R14 R15

	monitor_sampler #(
		.CNT_W(17),
		.FAST_CYCLES(SAMPLE_FAST_CYCLES),
		.SLOW_CYCLES(SAMPLE_SLOW_CYCLES)
	) u_sampler (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.run(mode_eff == supply_monitor_pkg::MODE_SAMPLED),
		.slow(samp_freq_q),
		.tick(sample_tick)
	);

	// reserved sleep code 3 is only legal for the active field; it reads as off in sleep
	always_comb begin
		unique case (mode_eff)
			supply_monitor_pkg::MODE_ENABLED: brownout_cmp_en = 1'b1; // R4 R19
			supply_monitor_pkg::MODE_SAMPLED: brownout_cmp_en = sample_tick; // R4
			supply_monitor_pkg::MODE_ENABLED_HOLD: brownout_cmp_en = !deep_sleep; // R19
			default: brownout_cmp_en = 1'b0;
		endcase
	end

	assign warn_cmp_en = brownout_cmp_en && irq_enable_q; // R7 R9
	assign warn_sample = warn_cmp_en && clk_en;
	assign brownout_level = level_q; // R6
	assign warn_level_select = warn_level_q; // R6 R20
	// hold the wake-up while the active mode asks to wait for the comparator
	assign wake_hold = !deep_sleep && active_q == supply_monitor_pkg::MODE_ENABLED_HOLD
		&& !monitor_ready; // R19

	// brownout reset request, taken from the comparator only while it runs
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			system_reset_q <= 1'b0;
		end else if (clk_en) begin
			system_reset_q <= brownout_cmp_en && below_brownout; // R5
		end
	end
	assign system_reset_req = system_reset_q;

	////////////////////////////////////////////////////////////////////////////
	// warning crossing detection and flag

	// the previous level is forgotten while the brownout comparator is off outside sampled mode, so a stale value fakes no crossing
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			below_q <= 1'b0;
			prev_valid_q <= 1'b0;
		end else if (clk_en) begin
			if (warn_cmp_en) begin
				below_q <= below_warn;
				prev_valid_q <= 1'b1;
			end else if (brownout_cmp_en == 1'b0 && mode_eff != supply_monitor_pkg::MODE_SAMPLED) begin
				prev_valid_q <= 1'b0; // R9
			end
		end
	end

	assign drop = prev_valid_q && !below_q && below_warn;
	assign recover = prev_valid_q && below_q && !below_warn;

	always_comb begin
		crossing = 1'b0;
		if (mode_eff == supply_monitor_pkg::MODE_SAMPLED) begin
			crossing = trigger_q == supply_monitor_pkg::TRIG_FROM_BELOW && drop; // R12
		end else begin
			unique case (trigger_q)
				supply_monitor_pkg::TRIG_FROM_ABOVE: crossing = drop; // R8
				supply_monitor_pkg::TRIG_FROM_BELOW: crossing = recover; // R8
				supply_monitor_pkg::TRIG_EITHER: crossing = drop || recover; // R8
				default: crossing = 1'b0; // R18
			endcase
		end
	end

	// enabling with the either-direction select flags once unless the monitor mode is disabled
	assign enable_edge = wr_irq_ctrl && !irq_enable_q
		&& req.wdata[supply_monitor_pkg::POS_IRQ_ENABLE]
		&& req.wdata[supply_monitor_pkg::POS_TRIGGER +: 2] == supply_monitor_pkg::TRIG_EITHER
		&& mode_eff != supply_monitor_pkg::MODE_DISABLED;
	assign set_flag = (warn_sample && crossing) || (clk_en && enable_edge);

	// a set in the same cycle as a clear wins, so no event is lost
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flag_q <= 1'b0;
		end else if (set_flag) begin
			flag_q <= 1'b1; // R13 R10
		end else if (clk_en && clear_flag) begin
			flag_q <= 1'b0; // R22
		end
	end

	// request withheld while the core is halted; monitoring itself goes on
	assign irq_req = flag_q && irq_enable_q && !debug_halt; // R13 R17

	////////////////////////////////////////////////////////////////////////////
	// read port

	// read data stands in the cycle after the strobe only
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_data_q <= 8'h00;
		end else if (clk_en) begin
			rd_data_q <= 8'h00;
			if (req.rd) begin
				unique case (req.addr)
					supply_monitor_pkg::OFF_MONITOR_CONTROL: rd_data_q <= {3'h0, samp_freq_q,
						active_q, sleep_q};
					supply_monitor_pkg::OFF_THRESHOLD: rd_data_q <= {5'h00, level_q};
					supply_monitor_pkg::OFF_WARN_CONTROL: rd_data_q <= {6'h00, warn_level_q};
					supply_monitor_pkg::OFF_IRQ_CONTROL: rd_data_q <= {5'h00, trigger_q, irq_enable_q};
					supply_monitor_pkg::OFF_IRQ_FLAGS: rd_data_q <= {7'h00, flag_q};
					supply_monitor_pkg::OFF_STATUS: rd_data_q <= {7'h00, below_q};
					default: rd_data_q <= 8'h00;
				endcase
			end
		end
	end
	assign rd_data = rd_data_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_fuse_load;
		@(posedge clk_sys) sys_rst |=> (level_q == $past(fuse_cfg.level)
			&& active_q == $past(fuse_cfg.active) && sleep_q == $past(fuse_cfg.sleep));
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("fuse values not loaded"); // R1

	property p_fixed_fields;
		@(posedge clk_sys) disable iff (sys_rst) wr_mon |=> $stable(active_q) && $stable(level_q);
	endproperty
	a_fixed_fields: assert property (p_fixed_fields) else $error("fixed field changed"); // R2

	property p_sleep_protect;
		@(posedge clk_sys) disable iff (sys_rst)
			(wr_mon && key_cnt_q == 3'h0) |=> $stable(sleep_q);
	endproperty
	a_sleep_protect: assert property (p_sleep_protect) else $error("unprotected sleep write"); // R21

	property p_sleep_unlocked;
		@(posedge clk_sys) disable iff (sys_rst)
			(clk_en && wr_key && req.wdata == supply_monitor_pkg::PROTECT_KEY_VALUE)
			##1 !wr_mon ##1 (clk_en && wr_mon) |=> sleep_q == $past(req.wdata[1:0]);
	endproperty
	a_sleep_unlocked: assert property (p_sleep_unlocked) else $error("keyed write lost"); // R3

	property p_sampled_pulse;
		@(posedge clk_sys) disable iff (sys_rst)
			(clk_en && mode_eff == supply_monitor_pkg::MODE_SAMPLED && brownout_cmp_en)
			##1 (mode_eff == supply_monitor_pkg::MODE_SAMPLED) |-> !brownout_cmp_en;
	endproperty
	a_sampled_pulse: assert property (p_sampled_pulse) else $error("sample longer than one cycle"); // R4

	property p_brownout_reset;
		@(posedge clk_sys) disable iff (sys_rst)
			(clk_en && brownout_cmp_en && below_brownout) |=> system_reset_req;
	endproperty
	a_brownout_reset: assert property (p_brownout_reset) else $error("no reset on brownout"); // R5

	property p_warn_off;
		@(posedge clk_sys) disable iff (sys_rst)
			mode_eff == supply_monitor_pkg::MODE_DISABLED |-> !warn_cmp_en && !brownout_cmp_en;
	endproperty
	a_warn_off: assert property (p_warn_off) else $error("warning active while monitor off"); // R9

	property p_sampled_trigger;
		@(posedge clk_sys) disable iff (sys_rst)
			(mode_eff == supply_monitor_pkg::MODE_SAMPLED && !flag_q && !enable_edge
			&& trigger_q != supply_monitor_pkg::TRIG_FROM_BELOW) |=> !flag_q;
	endproperty
	a_sampled_trigger: assert property (p_sampled_trigger) else $error("sampled flag on wrong code"); // R12

	property p_irq_hold;
		@(posedge clk_sys) disable iff (sys_rst)
			(irq_req && !clear_flag && $stable(irq_enable_q)) ##1 (!debug_halt
			&& !$changed(irq_enable_q)) |-> irq_req;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped with flag set"); // R13

	property p_flag_clear;
		@(posedge clk_sys) disable iff (sys_rst)
			(clk_en && clear_flag && !set_flag) |=> !flag_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // R22

	property p_debug_gate;
		@(posedge clk_sys) disable iff (sys_rst) debug_halt |-> !irq_req;
	endproperty
	a_debug_gate: assert property (p_debug_gate) else $error("request during debug halt"); // R17

	property p_sleep_entry;
		@(posedge clk_sys) disable iff (sys_rst)
			($rose(deep_sleep) && sleep_q == supply_monitor_pkg::MODE_DISABLED) |-> !brownout_cmp_en;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep mode not applied"); // R14

	c_flag_set: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(flag_q));
	c_sampled_tick: cover property (@(posedge clk_sys) disable iff (sys_rst)
		mode_eff == supply_monitor_pkg::MODE_SAMPLED && sample_tick);
	c_keyed_write: cover property (@(posedge clk_sys) disable iff (sys_rst)
		wr_mon && key_cnt_q != 3'h0);
	c_reset_req: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(system_reset_req));

endmodule : supply_monitor_control
`default_nettype wire
